// ==== dv/cbc_core_bench.sv ====
module cbc_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BT = cbc_pkg::OPC_BRANCH_IF_FLAG;
  localparam logic [7:0] BTS = cbc_pkg::OPC_DELAYED_BRANCH_IF_FLAG;
  logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic instr_valid = 1'h0, irq_req = 1'h0, addr_err = 1'h0;
  logic [7:0] paddr = '0;
  logic [15:0] instr_data = '0;
  logic [31:0] pwdata = '0, gpr_value = '0;
  logic pready, pslverr, slv, instr_ready, irq_accept, addr_err_accept, ill, flag, irq;
  logic [31:0] prdata, rd, pc, fetch_pc, acc_h, acc_l, ret;
  logic [3:0] gpr_sel;
  int fail_count = 0, checks_done = 0;
  always #10 clk = ~clk;
  cbc_core cbc_core_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_pc(fetch_pc), .instr_valid(instr_valid),
    .instr_data(instr_data), .instr_ready(instr_ready), .source_gpr(gpr_sel),
    .gpr_value(gpr_value), .irq_req(irq_req), .irq_accept(irq_accept),
    .addr_err(addr_err), .addr_err_accept(addr_err_accept), .illegal_slot_exc(ill),
    .cond_flag(flag), .accum_high(acc_h), .accum_low(acc_l), .return_addr_reg(ret),
    .irq(irq));
  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hi(input logic use_pready);
    int n;
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s = use_pready ? pready : instr_ready;
    end while (s !== 1'h1 && n < 50);
    if (s !== 1'h1) begin
      fail_count++;
      final_report();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    hi(1'h1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic ex(input logic [15:0] w);
    instr_valid <= 1'h1;
    instr_data <= w;
    hi(1'h0);
  endtask
  task automatic go();
    instr_valid <= 1'h0;
    hi(1'h0);
  endtask
  function automatic logic [31:0] tgt(input logic [7:0] d);
    tgt = pc + 32'h4 + {{23{d[7]}}, d, 1'h0};
  endfunction
  task automatic t_regs();
    apb(1'h0, cbc_pkg::OFS_CTRL, '0);
    chk("ctrl", rd, '0);
    apb(1'h1, 8'h44, 32'h5);
    chk("slverr", 32'(slv), 32'h1);
    apb(1'h1, cbc_pkg::OFS_PC, 32'h1000);
    apb(1'h0, cbc_pkg::OFS_PC, '0);
    chk("pc", rd, 32'h1000);
    apb(1'h1, cbc_pkg::OFS_CTRL, 32'h1);
    pc = 32'h1000;
  endtask
  task automatic t_ops();
    apb(1'h1, cbc_pkg::OFS_FLAG, 32'h1);
    ex(cbc_pkg::OPC_ZERO_ACCUMULATOR);
    ex(cbc_pkg::OPC_ZERO_FLAG);
    go();
    pc = pc + 32'h4;
    chk("acc", acc_h | acc_l, '0);
    chk("flag", 32'(flag), '0);
    chk("seq", fetch_pc, pc);
  endtask
  task automatic t_short();
    logic [7:0] d [2] = '{8'h80, 8'h7f};
    ex({BT, 8'h05});
    go();
    pc = pc + 32'h2;
    chk("bt_not", fetch_pc, pc);
    apb(1'h1, cbc_pkg::OFS_FLAG, 32'h1);
    foreach (d[i]) begin
      ex({BT, d[i]});
      go();
      pc = tgt(d[i]);
      chk("bt_taken", fetch_pc, pc);
    end
  endtask
  task automatic t_delay();
    irq_req <= 1'h1;
    addr_err <= 1'h1;
    ex({BTS, 8'h10});
    instr_valid <= 1'h0;
    @(posedge clk);
    chk("accept_win", 32'(irq_accept | addr_err_accept), '0);
    chk("slot_pc", fetch_pc, pc + 32'h2);
    apb(1'h0, cbc_pkg::OFS_SEQ_STATE, '0);
    chk("slot_state", rd, 32'h3);
    ex(16'h6303);
    go();
    pc = tgt(8'h10);
    chk("bts_taken", fetch_pc, pc);
    chk("accept_out", 32'(irq_accept), 32'h1);
    chk("err_out", 32'(addr_err_accept), 32'h1);
    irq_req <= 1'h0;
    addr_err <= 1'h0;
    apb(1'h0, cbc_pkg::OFS_EVT_STATUS, '0);
    chk("evt", rd, 32'h6);
    apb(1'h1, cbc_pkg::OFS_EVT_STATUS, 32'h7);
    apb(1'h1, cbc_pkg::OFS_FLAG, '0);
    ex({BTS, 8'h10});
    ex({BT, 8'h10});
    go();
    pc = pc + 32'h4;
    chk("bts_not", fetch_pc, pc);
    chk("no_ill", 32'(ill), '0);
  endtask
  task automatic t_far();
    gpr_value <= 32'h40;
    ex(16'h0203);
    chk("gpr_sel", 32'(gpr_sel), 32'h2);
    gpr_value <= 32'h1234;
    ex(16'h6303);
    go();
    chk("ret", ret, pc + 32'h4);
    chk("far", fetch_pc, pc + 32'h44);
    apb(1'h0, cbc_pkg::OFS_RET_ADDR, '0);
    chk("ret_rd", rd, pc + 32'h4);
    pc = pc + 32'h44;
  endtask
  task automatic t_ill();
    apb(1'h1, cbc_pkg::OFS_FLAG, 32'h1);
    ex({BTS, 8'h10});
    ex({BT, 8'h10});
    instr_valid <= 1'h0;
    @(posedge clk);
    chk("ill", 32'(ill), 32'h1);
    chk("ill_pc", fetch_pc, pc + 32'h2);
    apb(1'h0, cbc_pkg::OFS_EVT_STATUS, '0);
    chk("evt_ill", rd, 32'h3);
    chk("irq_masked", 32'(irq), '0);
    apb(1'h1, cbc_pkg::OFS_EVT_MASK, 32'h1);
    @(posedge clk);
    chk("irq_on", 32'(irq), 32'h1);
    apb(1'h1, cbc_pkg::OFS_EVT_STATUS, 32'h1);
    @(posedge clk);
    chk("irq_clr", 32'(irq), '0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    t_regs();
    t_ops();
    t_short();
    t_delay();
    t_far();
    t_ill();
    final_report();
  end
endmodule

// ==== dv/cbc_core_monitor.sv ====
module cbc_core_monitor (
  input logic clk,
  input logic resetn,
  input logic [31:0] fetch_pc,
  input logic instr_valid,
  input logic [15:0] instr_data,
  input logic instr_ready,
  input logic [31:0] gpr_value,
  input logic irq_accept,
  input logic addr_err_accept,
  input logic illegal_slot_exc,
  input logic cond_flag,
  input logic [31:0] return_addr_reg
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic fire, is_bt, is_bts, is_far, is_br, taken_d, win_reg;
  logic [31:0] tgt_reg, sdisp;
  assign fire = instr_valid && instr_ready;
  assign is_bt = instr_data[15:8] == cbc_pkg::OPC_BRANCH_IF_FLAG;
  assign is_bts = instr_data[15:8] == cbc_pkg::OPC_DELAYED_BRANCH_IF_FLAG;
  assign is_far = (instr_data & cbc_pkg::FAR_CALL_MASK) == cbc_pkg::FAR_CALL_MATCH;
  assign is_br = is_bt || is_bts || is_far;
  assign taken_d = is_far || (is_bts && cond_flag);
  assign sdisp = {{23{instr_data[7]}}, instr_data[7:0], 1'h0};
  // open from a taken delayed branch until its slot is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_reg <= 1'h0;
    end else if (fire) begin
      win_reg <= !win_reg && taken_d;
    end
  end
  // target fixed at the branch, later register changes cannot move it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tgt_reg <= '0;
    end else if (fire && !win_reg) begin
      tgt_reg <= fetch_pc + 32'h4 + (is_far ? gpr_value : sdisp);
    end
  end
  sequence s_stall2;
    !instr_ready [*2];
  endsequence
  sequence s_land;
    instr_ready && fetch_pc == tgt_reg;
  endsequence
  property p_bt_taken;
    fire && is_bt && cond_flag && !win_reg |=> s_stall2 ##1 s_land;
  endproperty
  a_bt_taken: assert property (p_bt_taken)
    else $error("short branch timing or target wrong");
  property p_seq;
    fire && !win_reg && !taken_d && !(is_bt && cond_flag)
      |=> instr_ready && fetch_pc == $past(fetch_pc) + 32'h2;
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequential step wrong");
  property p_delay;
    fire && taken_d && !win_reg
      |=> (!instr_ready && fetch_pc == $past(fetch_pc) + 32'h2) ##1 instr_ready;
  endproperty
  a_delay: assert property (p_delay)
    else $error("delayed branch timing wrong");
  property p_slot;
    fire && win_reg && !is_br |=> s_land;
  endproperty
  a_slot: assert property (p_slot)
    else $error("slot did not land on target");
  property p_shield;
    win_reg |-> !irq_accept && !addr_err_accept;
  endproperty
  a_shield: assert property (p_shield)
    else $error("exception accepted before slot");
  property p_illegal;
    fire && win_reg && is_br |=> (illegal_slot_exc && $stable(fetch_pc)) ##1 !illegal_slot_exc;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal slot not flagged");
  property p_far_ret;
    fire && is_far && !win_reg |=> return_addr_reg == $past(fetch_pc) + 32'h4;
  endproperty
  a_far_ret: assert property (p_far_ret)
    else $error("return address wrong");
  property p_zacc;
    fire && instr_data == cbc_pkg::OPC_ZERO_ACCUMULATOR |=> cond_flag == $past(cond_flag);
  endproperty
  a_zacc: assert property (p_zacc)
    else $error("accumulator clear touched flag");
  property p_zflag;
    fire && instr_data == cbc_pkg::OPC_ZERO_FLAG |=> !cond_flag;
  endproperty
  a_zflag: assert property (p_zflag)
    else $error("flag not cleared");
endmodule

bind cbc_core cbc_core_monitor cbc_core_monitor_inst (.clk(clk), .resetn(resetn),
  .fetch_pc(fetch_pc), .instr_valid(instr_valid), .instr_data(instr_data),
  .instr_ready(instr_ready), .gpr_value(gpr_value), .irq_accept(irq_accept),
  .addr_err_accept(addr_err_accept), .illegal_slot_exc(illegal_slot_exc),
  .cond_flag(cond_flag), .return_addr_reg(return_addr_reg));

// ==== rtl/cbc_core.sv ====
// Function
// RULE1 - flag set: short branch jumps, else falls through
// RULE2 - target base is branch address plus four
// RULE3 - displacement sign-extended, doubled, -256..+254
// RULE4 - short branch: three cycles taken, one not
// RULE5 - delayed branch: slot first, then target
// RULE6 - delayed branch: two cycles taken, one not
// RULE7 - no interrupt or address error before slot
// RULE8 - branch in slot raises illegal-slot exception
// RULE9 - branch register updates precede slot updates
// RULE10 - target captured before slot modifies registers
// RULE11 - zero accumulator pair, one cycle, flag kept
// RULE12 - zero flag op clears flag, one cycle
// RULE13 - far call saves return, jumps base+register
// RULE14 - untaken delayed branch: next instruction ordinary
// RULE15 - ordinary instructions advance pc by two
module cbc_core #(
  parameter int XLEN = cbc_pkg::XLEN,
  parameter int ADDR_W = cbc_pkg::ADDR_W
) (
  input logic clk,
  input logic resetn,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [XLEN-1:0] pwdata,
  output logic [XLEN-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction fetch
  output logic [XLEN-1:0] fetch_pc,
  input logic instr_valid,
  input logic [15:0] instr_data,
  output logic instr_ready,
  // general register read port
  output logic [3:0] source_gpr,
  input logic [XLEN-1:0] gpr_value,
  // exception sources from same-clock logic
  input logic irq_req,
  output logic irq_accept,
  input logic addr_err,
  output logic addr_err_accept,
  output logic illegal_slot_exc,
  // architectural state
  output logic cond_flag,
  output logic [XLEN-1:0] accum_high,
  output logic [XLEN-1:0] accum_low,
  output logic [XLEN-1:0] return_addr_reg,
  output logic irq
);
  cbc_pkg::cbc_seq_state_type state_reg;
  logic [XLEN-1:0] pc_reg;
  logic [XLEN-1:0] target_reg;
  logic [cbc_pkg::STALL_W-1:0] stall_reg;
  logic slot_pending_reg;
  logic run_reg;
  logic flag_reg;
  logic [XLEN-1:0] acc_high_reg;
  logic [XLEN-1:0] acc_low_reg;
  logic [XLEN-1:0] ret_reg;
  logic illegal_reg;
  logic [XLEN-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic is_bt;
  logic is_bts;
  logic is_far;
  logic is_zacc;
  logic is_zflag;
  logic is_branch;
  logic [XLEN-1:0] seq_pc;
  logic [XLEN-1:0] base_pc;
  logic [XLEN-1:0] disp_target;
  logic [XLEN-1:0] far_target;

  logic fire;
  logic in_exec;
  logic in_slot;
  logic stall_done;
  logic slot_window;
  logic apb_access;
  logic apb_write;
  logic addr_hit;
  logic [XLEN-1:0] read_mux;
  logic [cbc_pkg::EVT_W-1:0] evt_set;
  logic [cbc_pkg::EVT_W-1:0] evt_status;
  logic [cbc_pkg::EVT_W-1:0] evt_mask;

  cbc_decode u_decode (
    .instr(instr_data),
    .pc(pc_reg),
    .gpr_value(gpr_value),
    .is_bt(is_bt),
    .is_bts(is_bts),
    .is_far(is_far),
    .is_zacc(is_zacc),
    .is_zflag(is_zflag),
    .is_branch(is_branch),
    .seq_pc(seq_pc),
    .base_pc(base_pc),
    .disp_target(disp_target),
    .far_target(far_target)
  );

  // sequencing status
  assign in_exec = state_reg == cbc_pkg::SEQ_EXEC;
  assign in_slot = state_reg == cbc_pkg::SEQ_SLOT;
  assign stall_done = (state_reg == cbc_pkg::SEQ_STALL) &&
                      (stall_reg == cbc_pkg::STALL_W'(1));
  // from a taken delayed branch until its slot retires
  assign slot_window = in_slot || ((state_reg == cbc_pkg::SEQ_STALL) && slot_pending_reg);
  assign instr_ready = run_reg && (in_exec || in_slot);
  assign fire = instr_valid && instr_ready;
  assign fetch_pc = pc_reg;
  assign source_gpr = instr_data[cbc_pkg::GPR_HI:cbc_pkg::GPR_LO];

  assign irq_accept = irq_req && in_exec; // [RULE7]
  assign addr_err_accept = addr_err && !slot_window; // [RULE7]

  // apb decode, one wait state
  assign apb_access = psel && penable;
  assign apb_write = apb_access && pwrite && pready_reg;

  // instruction sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= cbc_pkg::SEQ_EXEC;
      pc_reg <= cbc_pkg::PC_RESET;
      target_reg <= '0;
      stall_reg <= '0;
      slot_pending_reg <= 1'b0;
    end else begin
      case (state_reg)
        cbc_pkg::SEQ_EXEC: begin
          if (apb_write && paddr == cbc_pkg::OFS_PC && !run_reg) begin
            pc_reg <= pwdata;
          end else if (fire) begin
            if (is_bt && flag_reg) begin
              target_reg <= disp_target; // [RULE1] [RULE2] [RULE3]
              stall_reg <= cbc_pkg::STALL_W'(cbc_pkg::BT_TAKEN_CYCLES - 1); // [RULE4]
              slot_pending_reg <= 1'b0;
              state_reg <= cbc_pkg::SEQ_STALL;
            end else if (is_bts && flag_reg) begin
              // target latched now, slot cannot disturb it
              target_reg <= disp_target; // [RULE10]
              pc_reg <= seq_pc; // [RULE5]
              stall_reg <= cbc_pkg::STALL_W'(cbc_pkg::DELAYED_TAKEN_CYCLES - 1); // [RULE6]
              slot_pending_reg <= 1'b1;
              state_reg <= cbc_pkg::SEQ_STALL;
            end else if (is_far) begin
              target_reg <= far_target; // [RULE13] [RULE10]
              pc_reg <= seq_pc;
              stall_reg <= cbc_pkg::STALL_W'(cbc_pkg::FAR_CALL_CYCLES - 1);
              slot_pending_reg <= 1'b1;
              state_reg <= cbc_pkg::SEQ_STALL;
            end else begin
              // not-taken branches fall through in one cycle
              pc_reg <= seq_pc; // [RULE1] [RULE4] [RULE6] [RULE14] [RULE15]
            end
          end
        end
        cbc_pkg::SEQ_STALL: begin
          if (stall_done) begin
            if (slot_pending_reg) begin
              state_reg <= cbc_pkg::SEQ_SLOT; // [RULE5]
            end else begin
              pc_reg <= target_reg; // [RULE1]
              state_reg <= cbc_pkg::SEQ_EXEC;
            end
          end else begin
            stall_reg <= stall_reg - cbc_pkg::STALL_W'(1);
          end
        end
        cbc_pkg::SEQ_SLOT: begin
          if (fire) begin
            slot_pending_reg <= 1'b0;
            state_reg <= cbc_pkg::SEQ_EXEC;
            if (!is_branch) begin
              // transfer only after the slot instruction retires
              pc_reg <= target_reg; // [RULE5] [RULE9]
            end
          end
        end
        default: begin
          state_reg <= cbc_pkg::SEQ_EXEC;
        end
      endcase
    end
  end

  // illegal slot exception pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      illegal_reg <= 1'b0;
    end else begin
      illegal_reg <= fire && in_slot && is_branch; // [RULE8]
    end
  end

  // condition flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (fire && is_zflag) begin
      flag_reg <= 1'b0; // [RULE12]
    end else if (apb_write && paddr == cbc_pkg::OFS_FLAG) begin
      flag_reg <= pwdata[cbc_pkg::FLAG_BIT];
    end
  end

  // accumulator pair, flag untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_high_reg <= '0;
      acc_low_reg <= '0;
    end else if (fire && is_zacc) begin
      acc_high_reg <= '0; // [RULE11]
      acc_low_reg <= '0; // [RULE11]
    end
  end

  // return address written in the branch cycle, ahead of the slot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ret_reg <= '0;
    end else if (fire && in_exec && is_far) begin
      ret_reg <= base_pc; // [RULE13] [RULE9]
    end
  end

  // run control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_reg <= 1'b0;
    end else if (apb_write && paddr == cbc_pkg::OFS_CTRL) begin
      run_reg <= pwdata[cbc_pkg::CTRL_RUN_BIT];
    end
  end

  // events
  always_comb begin
    evt_set = '0;
    evt_set[cbc_pkg::EVT_ILLEGAL_SLOT] = fire && in_slot && is_branch;
    evt_set[cbc_pkg::EVT_REDIRECT] = (stall_done && !slot_pending_reg) ||
                                     (fire && in_slot && !is_branch);
    evt_set[cbc_pkg::EVT_IRQ_HELD] = irq_req && slot_window; // [RULE7]
  end

  cbc_event_regs #(
    .W(cbc_pkg::EVT_W)
  ) u_events (
    .clk(clk),
    .resetn(resetn),
    .event_set(evt_set),
    .clear_wr(apb_write && paddr == cbc_pkg::OFS_EVT_STATUS),
    .clear_bits(pwdata[cbc_pkg::EVT_W-1:0]),
    .mask_wr(apb_write && paddr == cbc_pkg::OFS_EVT_MASK),
    .mask_bits(pwdata[cbc_pkg::EVT_W-1:0]),
    .status(evt_status),
    .mask(evt_mask),
    .irq(irq)
  );

  // register read mux
  always_comb begin
    read_mux = '0;
    addr_hit = 1'b1;
    case (paddr)
      cbc_pkg::OFS_CTRL: read_mux[cbc_pkg::CTRL_RUN_BIT] = run_reg;
      cbc_pkg::OFS_EVT_STATUS: read_mux[cbc_pkg::EVT_W-1:0] = evt_status;
      cbc_pkg::OFS_EVT_MASK: read_mux[cbc_pkg::EVT_W-1:0] = evt_mask;
      cbc_pkg::OFS_PC: read_mux = pc_reg;
      cbc_pkg::OFS_FLAG: read_mux[cbc_pkg::FLAG_BIT] = flag_reg;
      cbc_pkg::OFS_ACC_HIGH: read_mux = acc_high_reg;
      cbc_pkg::OFS_ACC_LOW: read_mux = acc_low_reg;
      cbc_pkg::OFS_RET_ADDR: read_mux = ret_reg;
      cbc_pkg::OFS_SEQ_STATE: begin
        read_mux[cbc_pkg::STATE_WINDOW_BIT] = slot_window;
        read_mux[cbc_pkg::STATE_SLOT_BIT] = in_slot;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // apb answer registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= apb_access && !pready_reg;
      if (apb_access && !pready_reg) begin
        pslverr_reg <= !addr_hit;
        prdata_reg <= pwrite ? '0 : read_mux;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign illegal_slot_exc = illegal_reg;
  assign cond_flag = flag_reg;
  assign accum_high = acc_high_reg;
  assign accum_low = acc_low_reg;
  assign return_addr_reg = ret_reg;
endmodule

// ==== rtl/cbc_decode.sv ====
// instruction classification and target arithmetic
module cbc_decode (
  input logic [15:0] instr,
  input logic [cbc_pkg::XLEN-1:0] pc,
  input logic [cbc_pkg::XLEN-1:0] gpr_value,
  output logic is_bt,
  output logic is_bts,
  output logic is_far,
  output logic is_zacc,
  output logic is_zflag,
  output logic is_branch,
  output logic [cbc_pkg::XLEN-1:0] seq_pc,
  output logic [cbc_pkg::XLEN-1:0] base_pc,
  output logic [cbc_pkg::XLEN-1:0] disp_target,
  output logic [cbc_pkg::XLEN-1:0] far_target
);
  logic [cbc_pkg::XLEN-1:0] disp_ext;

  assign is_bt = instr[cbc_pkg::OPC_HI:cbc_pkg::OPC_LO] == cbc_pkg::OPC_BRANCH_IF_FLAG;
  assign is_bts = instr[cbc_pkg::OPC_HI:cbc_pkg::OPC_LO] == cbc_pkg::OPC_DELAYED_BRANCH_IF_FLAG;
  assign is_far = (instr & cbc_pkg::FAR_CALL_MASK) == cbc_pkg::FAR_CALL_MATCH;
  assign is_zacc = instr == cbc_pkg::OPC_ZERO_ACCUMULATOR;
  assign is_zflag = instr == cbc_pkg::OPC_ZERO_FLAG;
  assign is_branch = is_bt | is_bts | is_far;

  assign seq_pc = pc + cbc_pkg::SEQ_STEP; // [RULE15]
  assign base_pc = pc + cbc_pkg::BRANCH_BASE_OFFSET; // [RULE2]
  // sign-extended 8-bit displacement, doubled
  assign disp_ext = {{(cbc_pkg::XLEN-9){instr[cbc_pkg::DISP_HI]}},
                     instr[cbc_pkg::DISP_HI:0], 1'b0}; // [RULE3]
  assign disp_target = base_pc + disp_ext; // [RULE3]
  assign far_target = base_pc + gpr_value; // [RULE13]
endmodule

// ==== rtl/cbc_event_regs.sv ====
// sticky event flags, write-one-to-clear, masked onto one level interrupt
module cbc_event_regs #(
  parameter int W = cbc_pkg::EVT_W
) (
  input logic clk,
  input logic resetn,
  input logic [W-1:0] event_set,
  input logic clear_wr,
  input logic [W-1:0] clear_bits,
  input logic mask_wr,
  input logic [W-1:0] mask_bits,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  logic [W-1:0] status_reg;
  logic [W-1:0] mask_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_evt
      // a set in the clearing cycle wins
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          status_reg[i] <= 1'b0;
        end else if (event_set[i]) begin
          status_reg[i] <= 1'b1;
        end else if (clear_wr && clear_bits[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= '0;
    end else if (mask_wr) begin
      mask_reg <= mask_bits;
    end
  end

  assign status = status_reg;
  assign mask = mask_reg;
  assign irq = |(status_reg & mask_reg);
endmodule

// ==== rtl/cbc_pkg.sv ====
package cbc_pkg;
  localparam int XLEN = 32;
  localparam int ADDR_W = 8;

  // opcode fields
  localparam logic [7:0] OPC_BRANCH_IF_FLAG = 8'h89;
  localparam logic [7:0] OPC_DELAYED_BRANCH_IF_FLAG = 8'h8d;
  localparam logic [15:0] OPC_ZERO_ACCUMULATOR = 16'h0028;
  localparam logic [15:0] OPC_ZERO_FLAG = 16'h0008;
  localparam logic [15:0] FAR_CALL_MASK = 16'hf0ff;
  localparam logic [15:0] FAR_CALL_MATCH = 16'h0003;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int GPR_HI = 11;
  localparam int GPR_LO = 8;
  localparam int DISP_HI = 7;

  // address arithmetic
  localparam logic [XLEN-1:0] BRANCH_BASE_OFFSET = 32'h0000_0004;
  localparam logic [XLEN-1:0] SEQ_STEP = 32'h0000_0002;
  localparam logic [XLEN-1:0] PC_RESET = 32'h0000_0000;

  // cycle counts per instruction form
  localparam int BT_TAKEN_CYCLES = 3;
  localparam int DELAYED_TAKEN_CYCLES = 2;
  localparam int FAR_CALL_CYCLES = 2;
  localparam int STALL_W = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ACC_HIGH = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ACC_LOW = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RET_ADDR = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_SEQ_STATE = 8'h20;

  localparam int CTRL_RUN_BIT = 0;
  localparam int FLAG_BIT = 0;
  localparam int STATE_WINDOW_BIT = 0;
  localparam int STATE_SLOT_BIT = 1;

  // event bits
  localparam int EVT_W = 3;
  localparam int EVT_ILLEGAL_SLOT = 0;
  localparam int EVT_REDIRECT = 1;
  localparam int EVT_IRQ_HELD = 2;

  typedef enum {
    SEQ_EXEC,
    SEQ_STALL,
    SEQ_SLOT
  } cbc_seq_state_type;
endpackage
